// ### rtl/pldt_pkg.sv
// pldt_pkg: shared constants, types and the register map of the test-access block
package pldt_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int NUM_MC = 24;
	localparam int GROUP_SIZE = 12;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_PR_TYP_NS = 600;
	localparam int T_PR_MAX_NS = 1000;
	// longest time, so rounded down
	localparam int PR_CYCLES = (T_PR_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
		T_PR_MAX_NS / CLK_PERIOD_NS;
	localparam int PR_CNT_W = $clog2(PR_CYCLES + 1);

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_COMB = 8'h08;
	localparam logic [7:0] OFF_POL = 8'h0C;
	localparam logic [7:0] OFF_PRIM = 8'h10;
	localparam logic [7:0] OFF_SEC = 8'h14;
	localparam logic [7:0] OFF_ARRAY = 8'h20;
	localparam int ARRAY_WORDS = 8;
	localparam int ARRAY_IDX_W = 3;

	localparam int CTRL_FUSE_BIT = 0;
	localparam int CTRL_OBS_PRIM_BIT = 1;
	localparam int STAT_CLEAR_BIT = 0;
	localparam int STAT_PRELOAD_BIT = 1;
	localparam int STAT_OBSERVE_BIT = 2;
	localparam int STAT_SECURE_BIT = 3;

	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [23:0] COMB_RST = 24'h000000;
	localparam logic [23:0] POL_RST = 24'hFFFFFF;
	localparam logic [31:0] ARRAY_RST = 32'h00000000;
	localparam logic [31:0] SECURE_READ = 32'hFFFFFFFF;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_CLEAR,
		MODE_RUN,
		MODE_PRELOAD,
		MODE_OBSERVE
	} pldt_mode_t;

	typedef struct packed {
		logic preload_hv;
		logic observe_hv;
		logic reg_sel;
		logic par_sel;
		logic pre_clk;
	} pldt_tester_t;

endpackage : pldt_pkg

// ### rtl/pldt_por.sv
// pldt_por: power-up clear interval timer
module pldt_por (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// status
	output logic busy_o
);

	logic [pldt_pkg::PR_CNT_W-1:0] cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= '0;
			busy_o <= 1'b1;
		end else if (ce_i && busy_o) begin
			cnt <= cnt + 1'b1;
			if (cnt == pldt_pkg::PR_CNT_W'(pldt_pkg::PR_CYCLES - 1)) begin
				busy_o <= 1'b0;
			end
		end
	end

	property p_por_end;
		@(posedge clk_i) disable iff (rst_i)
		(busy_o && ce_i && cnt == pldt_pkg::PR_CNT_W'(pldt_pkg::PR_CYCLES - 1)) |=> !busy_o;
	endproperty
	a_por_end: assert property (p_por_end) else $error("clear interval did not end");

	property p_por_start;
		@(posedge clk_i) $fell(rst_i) |-> busy_o && cnt == '0;
	endproperty
	a_por_start: assert property (p_por_start) else $error("clear interval not started");

endmodule : pldt_por

// ### rtl/pldt_regbank.sv
// pldt_regbank: the two flip-flops of every macrocell with preload and clear
module pldt_regbank (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// control
	input wire logic clear_i,
	input wire logic run_i,
	// functional terms
	input wire logic [pldt_pkg::NUM_MC-1:0] d1_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] d2_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] ck1_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] ck2_i,
	// preload path
	input wire logic [pldt_pkg::NUM_MC-1:0] pre_we1_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] pre_we2_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] pre_data_i,
	// state
	output logic [pldt_pkg::NUM_MC-1:0] prim_o,
	output logic [pldt_pkg::NUM_MC-1:0] sec_o
);

	for (genvar g = 0; g < pldt_pkg::NUM_MC; g++) begin : g_mc
		always_ff @(posedge clk_i) begin
			if (rst_i || clear_i) begin
				prim_o[g] <= 1'b0;
			end else if (ce_i) begin
				if (pre_we1_i[g]) begin
					prim_o[g] <= pre_data_i[g];
				end else if (run_i && ck1_i[g]) begin
					prim_o[g] <= d1_i[g];
				end
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i || clear_i) begin
				sec_o[g] <= 1'b0;
			end else if (ce_i) begin
				if (pre_we2_i[g]) begin
					sec_o[g] <= pre_data_i[g];
				end else if (run_i && ck2_i[g]) begin
					sec_o[g] <= d2_i[g];
				end
			end
		end
	end

endmodule : pldt_regbank

// ### rtl/pldt_core.sv
// pldt_core: preload, observability, power-up clear and security around 48 flip-flops

module pldt_core (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// tester pins
	input wire pldt_pkg::pldt_tester_t tester_i,
	// logic array terms
	input wire logic [pldt_pkg::NUM_MC-1:0] sum_d1_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] sum_d2_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] comb_term_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] ck1_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] ck2_i,
	input wire logic [pldt_pkg::NUM_MC-1:0] oe_term_i,
	// i/o pads
	input wire logic [pldt_pkg::NUM_MC-1:0] pad_i,
	output logic [pldt_pkg::NUM_MC-1:0] pad_o,
	output logic [pldt_pkg::NUM_MC-1:0] pad_oe_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [pldt_pkg::NUM_MC-1:0] pre_mask(input logic reg_sel,
		input logic par_sel, input logic want_sec);
		logic [pldt_pkg::NUM_MC-1:0] m;
		m = '0;
		for (int i = 0; i < pldt_pkg::NUM_MC; i++) begin
			m[i] = (i[0] == par_sel) && (reg_sel == want_sec);
		end
		return m;
	endfunction : pre_mask

	function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : wb_merge

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pldt_pkg::pldt_mode_t mode;
	pldt_pkg::pldt_mode_t next_mode;
	logic fuse;
	logic obs_prim;
	logic [pldt_pkg::NUM_MC-1:0] comb_cfg;
	logic [pldt_pkg::NUM_MC-1:0] pol_cfg;
	logic [31:0] cfg_array [pldt_pkg::ARRAY_WORDS];
	logic por_busy;
	logic pre_clk_q;
	logic [pldt_pkg::NUM_MC-1:0] prim;
	logic [pldt_pkg::NUM_MC-1:0] sec;
	logic pre_active;
	logic obs_active;
	logic pre_edge;
	logic [pldt_pkg::NUM_MC-1:0] pre_data;
	logic [pldt_pkg::NUM_MC-1:0] pre_we1;
	logic [pldt_pkg::NUM_MC-1:0] pre_we2;
	logic wb_req;
	logic wb_wr;
	logic in_array;
	logic [pldt_pkg::ARRAY_IDX_W-1:0] arr_idx;
	logic [31:0] rd_val;

	// ----------------------------------------------------------------
	// mode sequencing
	// ----------------------------------------------------------------
	always_comb begin
		next_mode = mode;
		case (mode)
			pldt_pkg::MODE_CLEAR: begin
				if (!por_busy) begin
					next_mode = pldt_pkg::MODE_RUN;
				end
			end
			pldt_pkg::MODE_RUN, pldt_pkg::MODE_PRELOAD, pldt_pkg::MODE_OBSERVE: begin
				// preload wins when both entries are raised together
				if (tester_i.preload_hv && !fuse) begin
					next_mode = pldt_pkg::MODE_PRELOAD;
				end else if (tester_i.observe_hv && !fuse) begin
					next_mode = pldt_pkg::MODE_OBSERVE;
				end else begin
					next_mode = pldt_pkg::MODE_RUN;
				end
			end
			default: begin
				next_mode = pldt_pkg::MODE_CLEAR;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= pldt_pkg::MODE_CLEAR;
		end else if (ce_i) begin
			mode <= next_mode;
		end
	end

	pldt_por u_por (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.busy_o(por_busy)
	);

	// ----------------------------------------------------------------
	// preload path
	// ----------------------------------------------------------------
	// entry and fuse gate directly, so a fuse write or a dropped entry acts at once
	assign pre_active = (mode == pldt_pkg::MODE_PRELOAD) && tester_i.preload_hv && !fuse;
	assign obs_active = (mode == pldt_pkg::MODE_OBSERVE) && tester_i.observe_hv && !fuse;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_clk_q <= 1'b0;
		end else if (ce_i) begin
			pre_clk_q <= tester_i.pre_clk;
		end
	end

	assign pre_edge = ce_i && pre_active && tester_i.pre_clk && !pre_clk_q;

	// odd pin 2k+1 feeds macrocells 2k and 2k+1; level taken as is, polarity ignored
	for (genvar k = 0; k < pldt_pkg::NUM_MC; k++) begin : g_pre_data
		assign pre_data[k] = pad_i[(k / 2) * 2 + 1];
	end

	assign pre_we1 = pre_edge ? pre_mask(tester_i.reg_sel, tester_i.par_sel, 1'b0) : '0;
	assign pre_we2 = pre_edge ? pre_mask(tester_i.reg_sel, tester_i.par_sel, 1'b1) : '0;

	pldt_regbank u_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.clear_i(mode == pldt_pkg::MODE_CLEAR),
		.run_i(mode == pldt_pkg::MODE_RUN || mode == pldt_pkg::MODE_OBSERVE),
		.d1_i(sum_d1_i),
		.d2_i(sum_d2_i),
		.ck1_i(ck1_i),
		.ck2_i(ck2_i),
		.pre_we1_i(pre_we1),
		.pre_we2_i(pre_we2),
		.pre_data_i(pre_data),
		.prim_o(prim),
		.sec_o(sec)
	);

	// ----------------------------------------------------------------
	// output pads
	// ----------------------------------------------------------------
	for (genvar m = 0; m < pldt_pkg::NUM_MC; m++) begin : g_pad
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				pad_o[m] <= 1'b0;
				pad_oe_o[m] <= 1'b0;
			end else if (ce_i) begin
				if (obs_active) begin
					// buried bank shown raw, no polarity applied
					pad_o[m] <= (obs_prim && comb_cfg[m]) ? prim[m] : sec[m];
					pad_oe_o[m] <= oe_term_i[m];
				end else if (mode == pldt_pkg::MODE_RUN) begin
					pad_o[m] <= (comb_cfg[m] ? comb_term_i[m] : prim[m]) ^ !pol_cfg[m];
					pad_oe_o[m] <= oe_term_i[m];
				end else begin
					// tester owns the pins in preload and clear
					pad_o[m] <= prim[m] ^ !pol_cfg[m];
					pad_oe_o[m] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = ce_i && wb_req && wb_we_i;
	assign in_array = wb_adr_i >= pldt_pkg::OFF_ARRAY &&
		wb_adr_i < pldt_pkg::OFF_ARRAY + 8'(4 * pldt_pkg::ARRAY_WORDS);
	assign arr_idx = wb_adr_i[pldt_pkg::ARRAY_IDX_W+1:2];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fuse <= pldt_pkg::CTRL_RST[pldt_pkg::CTRL_FUSE_BIT];
			obs_prim <= pldt_pkg::CTRL_RST[pldt_pkg::CTRL_OBS_PRIM_BIT];
		end else if (wb_wr && wb_adr_i == pldt_pkg::OFF_CTRL && wb_sel_i[0]) begin
			// fuse only ever sets; erasure is out of scope
			fuse <= fuse | wb_dat_i[pldt_pkg::CTRL_FUSE_BIT];
			obs_prim <= wb_dat_i[pldt_pkg::CTRL_OBS_PRIM_BIT];
		end
	end

	// pattern writes after the fuse would be lost to verify anyway, so block them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			comb_cfg <= pldt_pkg::COMB_RST;
			pol_cfg <= pldt_pkg::POL_RST;
		end else if (wb_wr && !fuse) begin
			if (wb_adr_i == pldt_pkg::OFF_COMB) begin
				comb_cfg <= 24'(wb_merge({8'h00, comb_cfg}, wb_dat_i, wb_sel_i));
			end
			if (wb_adr_i == pldt_pkg::OFF_POL) begin
				pol_cfg <= 24'(wb_merge({8'h00, pol_cfg}, wb_dat_i, wb_sel_i));
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < pldt_pkg::ARRAY_WORDS; i++) begin
				cfg_array[i] <= pldt_pkg::ARRAY_RST;
			end
		end else if (wb_wr && !fuse && in_array) begin
			cfg_array[arr_idx] <= wb_merge(cfg_array[arr_idx], wb_dat_i, wb_sel_i);
		end
	end

	always_comb begin
		rd_val = 32'h00000000;
		if (in_array) begin
			rd_val = fuse ? pldt_pkg::SECURE_READ : cfg_array[arr_idx];
		end else begin
			case (wb_adr_i)
				pldt_pkg::OFF_CTRL: begin
					rd_val[pldt_pkg::CTRL_FUSE_BIT] = fuse;
					rd_val[pldt_pkg::CTRL_OBS_PRIM_BIT] = obs_prim;
				end
				pldt_pkg::OFF_STAT: begin
					rd_val[pldt_pkg::STAT_CLEAR_BIT] = mode == pldt_pkg::MODE_CLEAR;
					rd_val[pldt_pkg::STAT_PRELOAD_BIT] = pre_active;
					rd_val[pldt_pkg::STAT_OBSERVE_BIT] = obs_active;
					rd_val[pldt_pkg::STAT_SECURE_BIT] = fuse;
				end
				pldt_pkg::OFF_COMB: begin
					rd_val = fuse ? pldt_pkg::SECURE_READ : {8'h00, comb_cfg};
				end
				pldt_pkg::OFF_POL: begin
					rd_val = fuse ? pldt_pkg::SECURE_READ : {8'h00, pol_cfg};
				end
				pldt_pkg::OFF_PRIM: begin
					rd_val = {8'h00, prim};
				end
				pldt_pkg::OFF_SEC: begin
					rd_val = {8'h00, sec};
				end
				default: begin
					rd_val = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (ce_i && wb_req && !wb_we_i) begin
			wb_dat_o <= rd_val;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_pre_prim_even;
		@(posedge clk_i) disable iff (rst_i)
		(pre_edge && !tester_i.reg_sel && !tester_i.par_sel) |=> prim[0] == $past(pad_i[1]);
	endproperty
	a_pre_prim_even: assert property (p_pre_prim_even) else $error("even primary preload wrong");

	property p_pre_sec_odd;
		@(posedge clk_i) disable iff (rst_i)
		(pre_edge && tester_i.reg_sel && tester_i.par_sel) |=> sec[23] == $past(pad_i[23]);
	endproperty
	a_pre_sec_odd: assert property (p_pre_sec_odd) else $error("odd secondary preload wrong");

	property p_pre_group;
		@(posedge clk_i) disable iff (rst_i)
		pre_edge |-> $countones(pre_we1 | pre_we2) == pldt_pkg::GROUP_SIZE;
	endproperty
	a_pre_group: assert property (p_pre_group) else $error("preload group not twelve");

	property p_pre_needs_hv;
		@(posedge clk_i) disable iff (rst_i)
		(!tester_i.preload_hv || fuse) |-> (pre_we1 == '0 && pre_we2 == '0);
	endproperty
	a_pre_needs_hv: assert property (p_pre_needs_hv) else $error("preload without entry");

	property p_fuse_blocks;
		@(posedge clk_i) disable iff (rst_i)
		fuse |-> !pre_active && !obs_active;
	endproperty
	a_fuse_blocks: assert property (p_fuse_blocks) else $error("fuse did not block test");

	property p_observe_sec;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && obs_active && oe_term_i[5] && !obs_prim) |=> pad_oe_o[5] && pad_o[5] == $past(sec[5]);
	endproperty
	a_observe_sec: assert property (p_observe_sec) else $error("buried secondary not observed");

	property p_observe_prim;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && obs_active && obs_prim && comb_cfg[4]) |=> pad_o[4] == $past(prim[4]);
	endproperty
	a_observe_prim: assert property (p_observe_prim) else $error("buried primary not observed");

	property p_clear_zero;
		@(posedge clk_i) disable iff (rst_i)
		(mode == pldt_pkg::MODE_CLEAR) ##1 (mode == pldt_pkg::MODE_CLEAR) |-> prim == '0 && sec == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("registers not cleared");

	property p_clear_ignores_ck;
		@(posedge clk_i) disable iff (rst_i)
		(mode == pldt_pkg::MODE_CLEAR && ck1_i[0] && sum_d1_i[0]) |=> prim[0] == 1'b0;
	endproperty
	a_clear_ignores_ck: assert property (p_clear_ignores_ck) else $error("clock during clear");

	property p_run_load;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && mode == pldt_pkg::MODE_RUN && ck2_i[7]) |=> sec[7] == $past(sum_d2_i[7]);
	endproperty
	a_run_load: assert property (p_run_load) else $error("functional load wrong");

	property p_secure_read;
		@(posedge clk_i) disable iff (rst_i)
		(wb_ack_o && !wb_we_i && fuse && $past(fuse) && wb_adr_i == pldt_pkg::OFF_COMB)
			|-> wb_dat_o == pldt_pkg::SECURE_READ;
	endproperty
	a_secure_read: assert property (p_secure_read) else $error("secure read leaked");

endmodule : pldt_core

// ### tb/pldt_tester_model.sv
// pldt_tester_model: tester at the pins driving the high-voltage entries and the pads
module pldt_tester_model (
	// clock
	input wire logic clk_i,
	// pins toward the device
	output pldt_pkg::pldt_tester_t tester_o,
	output logic [pldt_pkg::NUM_MC-1:0] pad_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		tester_o = '0;
		pad_o = 24'h000000;
	end

	// ----------------------------------------------------------------
	// preload frame: entry, pads, one clock pulse, exit
	// ----------------------------------------------------------------
	task automatic preload(input logic hv, input logic rs, input logic ps,
		input logic [pldt_pkg::NUM_MC-1:0] d);
		@(posedge clk_i);
		tester_o.preload_hv <= hv;
		tester_o.reg_sel <= rs;
		tester_o.par_sel <= ps;
		@(posedge clk_i);
		pad_o <= d;
		@(posedge clk_i);
		tester_o.pre_clk <= 1'b1;
		@(posedge clk_i);
		tester_o.pre_clk <= 1'b0;
		@(posedge clk_i);
		tester_o.preload_hv <= 1'b0;
		// pads stop carrying the data once the frame is over
		pad_o <= ~d;
	endtask : preload

	task automatic observe(input logic on);
		@(posedge clk_i);
		tester_o.observe_hv <= on;
	endtask : observe

endmodule : pldt_tester_model

// ### tb/pldt_core_test.sv
// pldt_core_test: self-checking bench of the preload, observe, clear and security logic
module pldt_core_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h00000000, rdat, rd;
	logic ack;
	pldt_pkg::pldt_tester_t tst;
	logic [23:0] d1 = 24'h000000, d2 = 24'h000000, ct = 24'h000000, ck1 = 24'h000000;
	logic [23:0] ck2 = 24'h000000;
	logic [23:0] oe = 24'h000000, pad, pad_o, pad_oe, prim_e, sec_e, dv, cm, pv;
	int seed = 90;
	int fail_count = 0;
	int tests_run = 0;

	always #25 clk_i = ~clk_i;

	pldt_tester_model u_tester (.clk_i(clk_i), .tester_o(tst), .pad_o(pad));

	pldt_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .tester_i(tst), .sum_d1_i(d1), .sum_d2_i(d2), .comb_term_i(ct),
		.ck1_i(ck1), .ck2_i(ck2), .oe_term_i(oe), .pad_i(pad), .pad_o(pad_o),
		.pad_oe_o(pad_oe));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chk("ack", 32'h1, 32'h0);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h00000000);
		chk(what, exp, rd);
	endtask : rdchk

	// the selected parity group takes the odd pad of its macrocell pair
	function automatic logic [23:0] pl(input logic [23:0] q, input logic ps, input logic [23:0] d);
		for (int m = 0; m < 24; m++) begin
			if ((m % 2) == ps) q[m] = d[(m / 2) * 2 + 1];
		end
		return q;
	endfunction : pl

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (6000) @(posedge clk_i);
		fail_count++;
		final_report();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		d2 <= 24'($random(seed));
		ct <= 24'($random(seed));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk("stat_clear", pldt_pkg::OFF_STAT, 32'h00000001);
		rdchk("prim_reset", pldt_pkg::OFF_PRIM, 32'h00000000);
		rdchk("sec_reset", pldt_pkg::OFF_SEC, 32'h00000000);
		// outside logic waits out the clear before any clock term
		repeat (pldt_pkg::PR_CYCLES + 2) @(posedge clk_i);
		rdchk("stat_run", pldt_pkg::OFF_STAT, 32'h00000000);
		chk("pad_pol_high", 32'h0, {8'h00, pad_o});
		wb(1'b1, pldt_pkg::OFF_POL, 32'h00000000);
		repeat (3) @(posedge clk_i);
		chk("pad_pol_low", 32'h00FFFFFF, {8'h00, pad_o});
		$display("test clear done");

		// polarity must not bend preload data
		pv = 24'($random(seed));
		wb(1'b1, pldt_pkg::OFF_POL, {8'h00, pv});
		prim_e = 24'h000000;
		sec_e = 24'h000000;
		for (int i = 0; i < 8; i++) begin
			dv = (i < 4) ? ((i % 2) ? 24'hFFFFFF : 24'h000000) : 24'($random(seed));
			u_tester.preload(1'b1, i[0], i[1], dv);
			if (i[0]) sec_e = pl(sec_e, i[1], dv);
			else prim_e = pl(prim_e, i[1], dv);
			rdchk("prim_preload", pldt_pkg::OFF_PRIM, {8'h00, prim_e});
			rdchk("sec_preload", pldt_pkg::OFF_SEC, {8'h00, sec_e});
		end
		u_tester.preload(1'b0, 1'b0, 1'b0, ~prim_e);
		rdchk("prim_no_entry", pldt_pkg::OFF_PRIM, {8'h00, prim_e});
		$display("test preload done");

		cm = 24'($random(seed));
		@(posedge clk_i);
		d1 <= 24'($random(seed));
		ck1 <= cm;
		ck2 <= ~cm;
		@(posedge clk_i);
		ck1 <= 24'h000000;
		ck2 <= 24'h000000;
		prim_e = (cm & d1) | (~cm & prim_e);
		sec_e = (~cm & d2) | (cm & sec_e);
		rdchk("prim_run_load", pldt_pkg::OFF_PRIM, {8'h00, prim_e});
		rdchk("sec_run_load", pldt_pkg::OFF_SEC, {8'h00, sec_e});
		$display("test run done");

		// bits 4 and 5 forced so both observe paths are exercised
		cm = 24'($random(seed)) | 24'h000010;
		wb(1'b1, pldt_pkg::OFF_COMB, {8'h00, cm});
		oe <= 24'($random(seed)) | 24'h000020;
		u_tester.observe(1'b1);
		repeat (3) @(posedge clk_i);
		chk("pad_observe_sec", {8'h00, sec_e}, {8'h00, pad_o});
		wb(1'b1, pldt_pkg::OFF_CTRL, 32'h00000002);
		repeat (2) @(posedge clk_i);
		chk("pad_observe", {8'h00, (cm & prim_e) | (~cm & sec_e)}, {8'h00, pad_o});
		chk("pad_oe_observe", {8'h00, oe}, {8'h00, pad_oe});
		u_tester.observe(1'b0);
		repeat (3) @(posedge clk_i);
		chk("pad_run", {8'h00, ((cm & ct) | (~cm & prim_e)) ^ ~pv}, {8'h00, pad_o});
		$display("test observe done");

		wb(1'b1, pldt_pkg::OFF_CTRL, 32'h00000001);
		rdchk("array_secure", pldt_pkg::OFF_ARRAY, pldt_pkg::SECURE_READ);
		rdchk("comb_secure", pldt_pkg::OFF_COMB, pldt_pkg::SECURE_READ);
		u_tester.preload(1'b1, 1'b0, 1'b1, ~prim_e);
		rdchk("prim_secure", pldt_pkg::OFF_PRIM, {8'h00, prim_e});
		u_tester.observe(1'b1);
		repeat (3) @(posedge clk_i);
		rdchk("stat_secure", pldt_pkg::OFF_STAT, 32'h00000008);
		rdchk("unmapped", 8'h40, 32'h00000000);
		$display("test security done");
		final_report();
	end

endmodule : pldt_core_test
